// [serdes_rx_regs.svh]
// offsets, field positions, reset values and timing counts of the rx status block
`ifndef SERDES_RX_REGS_SVH
`define SERDES_RX_REGS_SVH
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define CODE_ERR_CNT_OFFSET 8'h08
`define DISP_ERR_CNT_OFFSET 8'h0c
`define OVR_CNT_OFFSET 8'h10
`define REF_RANGE_OFFSET 8'h14
`define CTRL_TEN_BIT_INTERFACE_ENABLE_BIT 0
`define CTRL_WSE_BIT 1
`define CTRL_DOUBLE_RATE_ENABLE_BIT 2
`define CTRL_HSE_BIT 3
`define CTRL_RESTART_BIT 4
`define CTRL_RESET 4'h0
`define STATUS_STATE_LSB 0
`define STATUS_BYTE_ALIGNED_BIT 3
`define STATUS_WORD_ALIGNED_BIT 4
`define STATUS_REF_PRESENT_BIT 5
`define STATUS_LINK_READY_BIT 6
`define REF_MIN_FULL 16'h251c
`define REF_MAX_FULL 16'h34bc
`define REF_MIN_HALF 16'h128e
`define REF_MAX_HALF 16'h1a5e
`define REF_MIN_QUARTER 16'h0947
`define REF_MAX_QUARTER 16'h0d2f
`define CLK_PERIOD_PS 4000
`define BIT_TIME_PS 800
`define PLL_BIT_TIMES 10240
`define PLL_EXTRA_US 25
`define INIT_BIT_TIMES_NOWS 50
`define INIT_BIT_TIMES_WS 160
`define PLL_CYCLES ((`PLL_BIT_TIMES * `BIT_TIME_PS + `PLL_EXTRA_US * 1000000 \
   + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define INIT_CYCLES_NOWS ((`INIT_BIT_TIMES_NOWS * `BIT_TIME_PS \
   + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define INIT_CYCLES_WS ((`INIT_BIT_TIMES_WS * `BIT_TIME_PS \
   + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// [serdes_rx_pkg.sv]
// types shared by the rx status block
`default_nettype none
package serdes_rx_pkg;
   typedef enum logic [2:0] {
      ST_WAIT_REF,
      ST_PLL,
      ST_RX_INIT,
      ST_WORD_ALIGN,
      ST_RUN
   } startup_state_e;
   typedef logic [15:0] err_count_t;
endpackage
`default_nettype wire

// [rx_status_encoder.sv]
// priority encoder of receiver conditions onto the three status flags
`default_nettype none
module rx_status_encoder (
   input wire logic ten_bit,
   input wire logic data_bit8,
   input wire logic is_control,
   input wire logic is_idle,
   input wire logic code_err,
   input wire logic disp_err,
   input wire logic ovr_undr,
   input wire logic not_byte_sync,
   input wire logic not_word_sync,
   output logic err,
   output logic special,
   output logic idle
);
   // byte mode: lowest priority number wins
   wire logic b_err;
   wire logic b_special;
   wire logic b_idle;
   assign b_err = not_byte_sync ? 1'b1 :
      not_word_sync ? 1'b1 :
      ovr_undr ? 1'b0 :
      code_err ? 1'b1 :
      disp_err ? 1'b1 :
      1'b0;
   assign b_special = not_byte_sync ? 1'b1 :
      not_word_sync ? 1'b1 :
      ovr_undr ? 1'b0 :
      (code_err | disp_err) ? 1'b0 :
      (is_idle | is_control);
   assign b_idle = not_byte_sync ? 1'b0 :
      not_word_sync ? 1'b1 :
      ovr_undr ? 1'b1 :
      code_err ? 1'b0 :
      disp_err ? 1'b1 :
      is_idle;
   // ten-bit mode: the special line carries raw bit 8 of the character
   wire logic t_sync_lost;
   wire logic t_err;
   wire logic t_idle;
   assign t_sync_lost = not_byte_sync | not_word_sync;
   assign t_err = t_sync_lost | ovr_undr;
   assign t_idle = t_sync_lost ? 1'b0 :
      ovr_undr ? 1'b1 :
      is_idle;
   assign err = ten_bit ? t_err : b_err;
   assign special = ten_bit ? data_bit8 : b_special;
   assign idle = ten_bit ? t_idle : b_idle;
endmodule
`default_nettype wire

// [serdes_rx_status.sv]
// rx status flag encoding, cold start-up sequencer and register port
// Overview of operation
// - error flag low means normal operation, except byte-mode overrun code
// - error flag is high from the start of start-up
// - byte mode valid data: all flags low, priority 8
// - byte mode overrun/underrun: idle flag only, priority 3
// - byte mode control character: special flag only, priority 7
// - byte mode idle character: special and idle high, priority 6
// - byte mode code error: error flag only, priority 4
// - byte mode disparity error: error and idle high, priority 5
// - byte mode no byte sync: error and special high, priority 1
// - byte mode no word sync: all three flags high, priority 2
// - ten-bit mode non-idle character: error and idle low, priority 4
// - ten-bit mode idle character: idle high, priority 3
// - ten-bit mode start-up or sync loss: error high, priority 1
// - ten-bit mode overrun/underrun: error and idle high, priority 2
// - cold start-up begins when the reference clock appears
// - order is PLL, receiver init and byte align, word align, run
// - low reset restarts the whole cold start-up
// - PLL 10240 bit times plus 25 us; init and word align 50 or 160
// - code or disparity error flags only the one character output
//
// The plain strobed port and the address map are this design's own decisions.
`default_nettype none
`include "serdes_rx_regs.svh"
module serdes_rx_status #(
   parameter int PLL_CYCLES = `PLL_CYCLES,
   parameter int INIT_CYCLES_NOWS = `INIT_CYCLES_NOWS,
   parameter int INIT_CYCLES_WS = `INIT_CYCLES_WS,
   parameter int CNT_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ref_clk_present,
   input wire logic char_valid,
   input wire logic [9:0] char_data,
   input wire logic char_is_control,
   input wire logic char_is_idle,
   input wire logic char_code_err,
   input wire logic char_disp_err,
   input wire logic char_ovr_undr,
   input wire logic byte_aligned,
   input wire logic word_aligned,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [9:0] rx_data,
   output logic rx_strobe,
   output logic rx_error_flag,
   output logic rx_special_flag,
   output logic rx_idle_flag,
   output logic rx_init_active,
   output logic link_ready
);
   // 64-bit shift so that a 32-bit counter does not wrap the limit to zero
   if (PLL_CYCLES < 1 || PLL_CYCLES >= (64'h1 << CNT_W)) begin : g_chk_pll
      $error("PLL_CYCLES does not fit the step counter");
   end
   if (INIT_CYCLES_NOWS < 1 || INIT_CYCLES_WS < 1 ||
       INIT_CYCLES_WS >= (64'h1 << CNT_W) ||
       INIT_CYCLES_NOWS >= (64'h1 << CNT_W)) begin : g_chk_init
      $error("init step counts do not fit the step counter");
   end
   if (CNT_W < 8 || CNT_W > 32) begin : g_chk_w
      $error("CNT_W must lie between 8 and 32");
   end

   localparam logic [CNT_W-1:0] PLL_LAST = CNT_W'(PLL_CYCLES - 1);
   localparam logic [CNT_W-1:0] INIT_LAST_NOWS = CNT_W'(INIT_CYCLES_NOWS - 1);
   localparam logic [CNT_W-1:0] INIT_LAST_WS = CNT_W'(INIT_CYCLES_WS - 1);

   // reference clock detect is a pin: two flops before anything reads it
   logic ref_meta_q;
   logic ref_sync_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ref_meta_q <= 1'b0;
         ref_sync_q <= 1'b0;
      end else begin
         ref_meta_q <= ref_clk_present;
         ref_sync_q <= ref_meta_q;
      end
   end

   // control register
   logic ten_bit_interface_enable_q;
   logic wse_q;
   logic double_rate_enable_q;
   logic hse_q;
   logic restart_q;
   wire logic sel_ctrl;
   wire logic sel_status;
   wire logic sel_code;
   wire logic sel_disp;
   wire logic sel_ovr;
   wire logic sel_range;
   wire logic ctrl_wr;
   assign sel_ctrl = reg_addr == `CTRL_OFFSET;
   assign sel_status = reg_addr == `STATUS_OFFSET;
   assign sel_code = reg_addr == `CODE_ERR_CNT_OFFSET;
   assign sel_disp = reg_addr == `DISP_ERR_CNT_OFFSET;
   assign sel_ovr = reg_addr == `OVR_CNT_OFFSET;
   assign sel_range = reg_addr == `REF_RANGE_OFFSET;
   assign ctrl_wr = reg_wr & sel_ctrl;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {hse_q, double_rate_enable_q, wse_q, ten_bit_interface_enable_q} <= `CTRL_RESET;
      end else if (ctrl_wr) begin
         ten_bit_interface_enable_q <= reg_wdata[`CTRL_TEN_BIT_INTERFACE_ENABLE_BIT];
         wse_q <= reg_wdata[`CTRL_WSE_BIT];
         double_rate_enable_q <= reg_wdata[`CTRL_DOUBLE_RATE_ENABLE_BIT];
         hse_q <= reg_wdata[`CTRL_HSE_BIT];
      end
   end

   // restart is a one-cycle command, never stored as a level
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         restart_q <= 1'b0;
      end else begin
         restart_q <= ctrl_wr & reg_wdata[`CTRL_RESTART_BIT];
      end
   end

   // start-up sequencer
   serdes_rx_pkg::startup_state_e state_q;
   serdes_rx_pkg::startup_state_e state_d;
   logic [CNT_W-1:0] step_cnt_q;
   wire logic [CNT_W-1:0] init_last;
   wire logic step_done;
   wire logic state_change;
   assign init_last = wse_q ? INIT_LAST_WS : INIT_LAST_NOWS;
   assign step_done = (state_q == serdes_rx_pkg::ST_PLL) ?
      (step_cnt_q >= PLL_LAST) : (step_cnt_q >= init_last);

   always_comb begin
      state_d = state_q;
      case (state_q)
         serdes_rx_pkg::ST_WAIT_REF: begin
            if (ref_sync_q) begin
               state_d = serdes_rx_pkg::ST_PLL;
            end
         end
         serdes_rx_pkg::ST_PLL: begin
            if (step_done) begin
               state_d = serdes_rx_pkg::ST_RX_INIT;
            end
         end
         serdes_rx_pkg::ST_RX_INIT: begin
            if (step_done && byte_aligned) begin
               state_d = wse_q ? serdes_rx_pkg::ST_WORD_ALIGN :
                  serdes_rx_pkg::ST_RUN;
            end
         end
         serdes_rx_pkg::ST_WORD_ALIGN: begin
            if (!byte_aligned) begin
               state_d = serdes_rx_pkg::ST_RX_INIT;
            end else if (!wse_q || (step_done && word_aligned)) begin
               state_d = serdes_rx_pkg::ST_RUN;
            end
         end
         serdes_rx_pkg::ST_RUN: begin
            if (!byte_aligned) begin
               state_d = serdes_rx_pkg::ST_RX_INIT;
            end else if (wse_q && !word_aligned) begin
               state_d = serdes_rx_pkg::ST_WORD_ALIGN;
            end
         end
         default: begin
            state_d = serdes_rx_pkg::ST_WAIT_REF;
         end
      endcase
      // losing the reference clock or a soft restart is a cold start
      if (!ref_sync_q || restart_q) begin
         state_d = serdes_rx_pkg::ST_WAIT_REF;
      end
   end

   assign state_change = state_d != state_q;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= serdes_rx_pkg::ST_WAIT_REF;
      end else begin
         state_q <= state_d;
      end
   end

   // step timer restarts on every state change and saturates
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         step_cnt_q <= '0;
      end else if (state_change) begin
         step_cnt_q <= '0;
      end else if (step_cnt_q != {CNT_W{1'b1}}) begin
         step_cnt_q <= step_cnt_q + CNT_W'(1);
      end
   end

   // sync conditions seen by the encoder
   wire logic not_byte_sync;
   wire logic not_word_sync;
   wire logic in_run;
   assign in_run = state_q == serdes_rx_pkg::ST_RUN;
   assign not_byte_sync = (state_q != serdes_rx_pkg::ST_RUN &&
      state_q != serdes_rx_pkg::ST_WORD_ALIGN) || !byte_aligned;
   assign not_word_sync = wse_q && (!in_run || !word_aligned);

   wire logic enc_err;
   wire logic enc_special;
   wire logic enc_idle;
   // byte-mode decode errors are meaningless while the decoder is bypassed
   rx_status_encoder u_enc (
      .ten_bit(ten_bit_interface_enable_q),
      .data_bit8(char_data[8]),
      .is_control(char_is_control),
      .is_idle(char_is_idle),
      .code_err(char_code_err),
      .disp_err(char_disp_err),
      .ovr_undr(char_ovr_undr),
      .not_byte_sync(not_byte_sync),
      .not_word_sync(not_word_sync),
      .err(enc_err),
      .special(enc_special),
      .idle(enc_idle)
   );

   // flags follow each character; while out of byte sync they hold the
   // search code even between characters so start-up is always visible
   wire logic flag_load;
   assign flag_load = char_valid | not_byte_sync;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_error_flag <= 1'b1;
         rx_special_flag <= 1'b1;
         rx_idle_flag <= 1'b0;
      end else if (flag_load) begin
         rx_error_flag <= enc_err;
         rx_special_flag <= enc_special;
         rx_idle_flag <= enc_idle;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_data <= '0;
         rx_strobe <= 1'b0;
      end else begin
         rx_strobe <= char_valid;
         if (char_valid) begin
            rx_data <= char_data;
         end
      end
   end

   // partner may send payload only once link_ready is seen
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         link_ready <= 1'b0;
         rx_init_active <= 1'b0;
      end else begin
         link_ready <= state_d == serdes_rx_pkg::ST_RUN;
         rx_init_active <= state_d == serdes_rx_pkg::ST_RX_INIT;
      end
   end

   // error counters: code, disparity, overrun; write clears, event wins
   localparam int NCNT = 3;
   serdes_rx_pkg::err_count_t err_cnt_q [NCNT];
   wire logic [NCNT-1:0] cnt_inc;
   wire logic [NCNT-1:0] cnt_clr;
   wire logic count_ok;
   assign count_ok = char_valid && in_run && !ten_bit_interface_enable_q;
   assign cnt_inc[0] = count_ok && char_code_err;
   assign cnt_inc[1] = count_ok && char_disp_err;
   assign cnt_inc[2] = char_valid && in_run && char_ovr_undr;
   assign cnt_clr[0] = reg_wr && sel_code;
   assign cnt_clr[1] = reg_wr && sel_disp;
   assign cnt_clr[2] = reg_wr && sel_ovr;

   for (genvar i = 0; i < NCNT; i++) begin : g_cnt
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            err_cnt_q[i] <= '0;
         end else if (cnt_clr[i]) begin
            err_cnt_q[i] <= {15'h0000, cnt_inc[i]};
         end else if (cnt_inc[i] && err_cnt_q[i] != 16'hffff) begin
            err_cnt_q[i] <= err_cnt_q[i] + 16'h0001;
         end
      end
   end

   // legal reference clock window for the selected rate options
   wire logic [15:0] ref_min;
   wire logic [15:0] ref_max;
   wire logic [1:0] rate_halvings;
   assign rate_halvings = {1'b0, double_rate_enable_q} + {1'b0, hse_q};
   assign ref_min = (rate_halvings == 2'h0) ? `REF_MIN_FULL :
      (rate_halvings == 2'h1) ? `REF_MIN_HALF : `REF_MIN_QUARTER;
   assign ref_max = (rate_halvings == 2'h0) ? `REF_MAX_FULL :
      (rate_halvings == 2'h1) ? `REF_MAX_HALF : `REF_MAX_QUARTER;

   // read mux; unmapped addresses read zero
   wire logic [31:0] ctrl_word;
   wire logic [31:0] status_word;
   wire logic [31:0] rd_mux;
   assign ctrl_word = {28'h0000000, hse_q, double_rate_enable_q, wse_q, ten_bit_interface_enable_q};
   assign status_word = {25'h0000000, link_ready, ref_sync_q, word_aligned,
      byte_aligned, state_q};
   assign rd_mux = sel_ctrl ? ctrl_word :
      sel_status ? status_word :
      sel_code ? {16'h0000, err_cnt_q[0]} :
      sel_disp ? {16'h0000, err_cnt_q[1]} :
      sel_ovr ? {16'h0000, err_cnt_q[2]} :
      sel_range ? {ref_max, ref_min} :
      32'h00000000;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= '0;
      end
   end
endmodule
`default_nettype wire

// [serdes_rx_checker.sv]
// port assertions for the rx status block
`default_nettype none
module serdes_rx_checker #(
   parameter int INIT_CYCLES_NOWS = 10,
   parameter int INIT_CYCLES_WS = 32
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic char_valid,
   input wire logic [9:0] char_data,
   input wire logic char_is_control,
   input wire logic char_is_idle,
   input wire logic char_code_err,
   input wire logic char_disp_err,
   input wire logic char_ovr_undr,
   input wire logic byte_aligned,
   input wire logic word_aligned,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [9:0] rx_data,
   input wire logic rx_strobe,
   input wire logic rx_error_flag,
   input wire logic rx_special_flag,
   input wire logic rx_idle_flag,
   input wire logic rx_init_active,
   input wire logic link_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ctrl_q;
   logic [7:0] init_cnt_q;
   wire logic [2:0] flags = {rx_error_flag, rx_special_flag, rx_idle_flag};
   wire logic tbi = ctrl_q[0];
   wire logic word_sync_enable = ctrl_q[1];
   wire logic run_ok = link_ready && byte_aligned && (!word_sync_enable || word_aligned);
   wire logic [2:0] byte_exp = char_ovr_undr ? 3'h1 : char_code_err ? 3'h4 :
      char_disp_err ? 3'h5 : char_is_idle ? 3'h3 : {1'b0, char_is_control, 1'b0};
   wire logic [2:0] tbi_exp = {char_ovr_undr, char_data[8],
      char_ovr_undr | char_is_idle};
   wire logic [31:0] range_exp = (ctrl_q[2] && ctrl_q[3]) ? 32'h0d2f0947 :
      (ctrl_q[2] || ctrl_q[3]) ? 32'h1a5e128e : 32'h34bc251c;
   // mirror of the mode bits, so codes can be predicted per mode
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= 4'h0;
         init_cnt_q <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == 8'h00)
            ctrl_q <= reg_wdata[3:0];
         init_cnt_q <= rx_init_active ? init_cnt_q + 8'h01 : 8'h00;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_char_run;
      run_ok && char_valid;
   endsequence
   sequence s_run_entry;
      !link_ready ##1 link_ready;
   endsequence
   chk_strobe_pulse:
      assert property (char_valid |=> rx_strobe && rx_data == $past(char_data))
      else $error("no strobe or data after char");
   chk_strobe_quiet:
      assert property (!char_valid |=> !rx_strobe)
      else $error("strobe without char");
   chk_reset_code:
      assert property ($rose(rst_b) |-> flags == 3'h6 && !link_ready)
      else $error("wrong code at reset release");
   chk_err_startup:
      assert property (!link_ready |=> rx_error_flag)
      else $error("error flag low before run");
   chk_sync_lost:
      assert property (!tbi && !byte_aligned |=> flags == 3'h6)
      else $error("sync lost code missing");
   chk_byte_codes:
      assert property (s_char_run ##0 !tbi |=> flags == $past(byte_exp))
      else $error("byte mode code wrong");
   chk_tbi_codes:
      assert property (s_char_run ##0 tbi |=> flags == $past(tbi_exp))
      else $error("ten-bit code wrong");
   chk_flags_hold:
      assert property (run_ok && !char_valid |=> $stable(flags))
      else $error("flags moved without char");
   chk_range_read:
      assert property (reg_rd && reg_addr == 8'h14 |=>
         reg_rdata == $past(range_exp))
      else $error("reference range wrong");
   chk_rdata_idle:
      assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   chk_init_len:
      assert property ($fell(rx_init_active) |->
         init_cnt_q >= (word_sync_enable ? INIT_CYCLES_WS : INIT_CYCLES_NOWS))
      else $error("receiver init too short");
   chk_run_entry:
      assert property (s_run_entry |-> $past(rx_init_active) != word_sync_enable)
      else $error("run entered from wrong step");
endmodule
bind serdes_rx_status serdes_rx_checker #(
   .INIT_CYCLES_NOWS(INIT_CYCLES_NOWS),
   .INIT_CYCLES_WS(INIT_CYCLES_WS)
) u_chk (.clk_sys, .rst_b, .char_valid, .char_data, .char_is_control,
   .char_is_idle, .char_code_err, .char_disp_err, .char_ovr_undr,
   .byte_aligned, .word_aligned, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .rx_data, .rx_strobe, .rx_error_flag, .rx_special_flag,
   .rx_idle_flag, .rx_init_active, .link_ready);
`default_nettype wire

// [rx_sink_model.sv]
// far-side consumer: latches each character and its status on the strobe
`default_nettype none
module rx_sink_model (
   input wire logic clk_sys,
   input wire logic rx_strobe,
   input wire logic [9:0] rx_data,
   input wire logic [2:0] rx_flags,
   output var logic [12:0] last_char,
   output var int num_chars
);
   timeunit 1ns;
   timeprecision 1ps;
   initial num_chars = 0;
   // only a clean strobe counts, so an unknown never passes as a char
   always @(posedge clk_sys) begin
      if (rx_strobe === 1'b1) begin
         last_char <= {rx_flags, rx_data};
         num_chars <= num_chars + 1;
      end
   end
endmodule
`default_nettype wire

// [tb_serdes_rx_status.sv]
// self-checking bench for the rx status block
`default_nettype none
module tb_serdes_rx_status;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PLL_N = 20;
   localparam int INIT_N = 10;
   localparam int INIT_WS_N = 32;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic ref_clk_present = 1'b0;
   logic char_valid = 1'b0;
   logic [9:0] char_data = 10'h000;
   logic [4:0] kind = 5'h00;
   logic byte_aligned = 1'b1;
   logic word_aligned = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] rd;
   logic [9:0] rx_data;
   logic rx_strobe;
   wire logic [2:0] flags;
   logic rx_init_active;
   logic link_ready;
   logic [12:0] last_char;
   int num_chars;
   int mismatches = 0;
   int num_checks = 0;
   logic [4:0] kinds [8] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01,
      5'h0e, 5'h0b};
   logic [2:0] codes [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h4, 3'h1};
   logic [31:0] ranges [4] = '{32'h34bc251c, 32'h1a5e128e, 32'h1a5e128e,
      32'h0d2f0947};
   always #2 clk_sys = ~clk_sys;
   serdes_rx_status #(.PLL_CYCLES(PLL_N)) dut (.clk_sys(clk_sys),
      .rst_b(rst_b), .ref_clk_present(ref_clk_present),
      .char_valid(char_valid), .char_data(char_data),
      .char_is_control(kind[4]), .char_is_idle(kind[3]),
      .char_code_err(kind[2]), .char_disp_err(kind[1]),
      .char_ovr_undr(kind[0]), .byte_aligned(byte_aligned),
      .word_aligned(word_aligned), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_data(rx_data), .rx_strobe(rx_strobe),
      .rx_error_flag(flags[2]), .rx_special_flag(flags[1]),
      .rx_idle_flag(flags[0]), .rx_init_active(rx_init_active),
      .link_ready(link_ready));
   rx_sink_model sink (.clk_sys(clk_sys), .rx_strobe(rx_strobe),
      .rx_data(rx_data), .rx_flags(flags), .last_char(last_char),
      .num_chars(num_chars));
   task automatic cmp_word(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_char(input logic [12:0] e, input int n);
      num_checks++;
      if (last_char !== e || num_chars != n) begin
         mismatches++;
         $display("mismatch char expected %h seen %h", e, last_char);
      end
   endtask
   // char offered for one cycle, then judged as the consumer saw it
   task automatic send(input logic [4:0] k, input logic [9:0] d,
      input logic [2:0] code);
      int n;
      n = num_chars + 1;
      @(posedge clk_sys);
      char_valid <= 1'b1;
      kind <= k;
      char_data <= d;
      @(posedge clk_sys);
      char_valid <= 1'b0;
      @(posedge clk_sys);
      #1;
      cmp_char({code, d}, n);
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // bounded wait; run must not come sooner than the start-up steps allow
   task automatic wait_run(input int min_n);
      int i;
      // look after the edge has settled, never in the launching time step
      for (i = 0; i < 500 && link_ready !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      cmp_word("run_reached", 32'h1, {31'h0, link_ready});
      cmp_word("run_time", 32'h1, {31'h0, i >= min_n});
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      reg_write(8'h00, 32'h0);
      send(5'h00, 10'h0a5, 3'h6);
      @(posedge clk_sys);
      ref_clk_present <= 1'b1;
      wait_run(PLL_N + INIT_N);
      $display("test startup done");
      for (int k = 0; k < 8; k++)
         send(kinds[k], 10'(k + 3), codes[k]);
      reg_read(8'h08, rd);
      cmp_word("code_count", 32'h2, rd);
      reg_read(8'h0c, rd);
      cmp_word("disp_count", 32'h3, rd);
      reg_write(8'h0c, 32'h0);
      reg_read(8'h0c, rd);
      cmp_word("disp_cleared", 32'h0, rd);
      $display("test byte codes done");
      reg_write(8'h00, 32'h1);
      send(5'h00, 10'h17c, 3'h2);
      send(5'h08, 10'h0bc, 3'h1);
      send(5'h01, 10'h100, 3'h7);
      send(5'h04, 10'h055, 3'h0);
      @(posedge clk_sys);
      byte_aligned <= 1'b0;
      send(5'h00, 10'h000, 3'h4);
      cmp_word("ready_lost", 32'h0, {31'h0, link_ready});
      $display("test ten-bit done");
      @(posedge clk_sys);
      byte_aligned <= 1'b1;
      reg_write(8'h00, 32'h2);
      repeat (40) @(posedge clk_sys);
      send(5'h01, 10'h011, 3'h7);
      @(posedge clk_sys);
      word_aligned <= 1'b1;
      wait_run(INIT_N);
      send(5'h00, 10'h022, 3'h0);
      $display("test word sync done");
      for (int m = 0; m < 4; m++) begin
         reg_write(8'h00, {28'h0, 2'(m), 2'h2});
         reg_read(8'h14, rd);
         cmp_word("ref_range", ranges[m], rd);
      end
      // soft restart with word sync on: PLL, init and word align all run
      reg_write(8'h00, 32'h12);
      repeat (2) @(posedge clk_sys);
      wait_run(PLL_N + 2 * INIT_WS_N);
      reg_read(8'h04, rd);
      cmp_word("status_state", 32'h4, rd & 32'h7);
      reg_read(8'h20, rd);
      cmp_word("unmapped", 32'h0, rd);
      $display("test registers done");
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      cmp_word("reset_flags", 32'h6, {29'h0, flags});
      cmp_word("reset_ready", 32'h0, {31'h0, link_ready});
      @(posedge clk_sys);
      rst_b <= 1'b1;
      wait_run(PLL_N + INIT_N);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule
`default_nettype wire
